// file: pkg/dtp_params.svh
// register indices, field positions, reset values and timing for the dual timer block
`ifndef DTP_PARAMS_SVH
`define DTP_PARAMS_SVH
// register indices, byte address is four times the index
`define DTP_IDX_FIRST_TIMER_COUNT    8'h01
`define DTP_IDX_PORTA   8'h05
`define DTP_IDX_T1L     8'h0e
`define DTP_IDX_T1H     8'h0f
`define DTP_IDX_SECOND_TIMER_CONTROL   8'h10
`define DTP_IDX_ISTAT   8'h20
`define DTP_IDX_IEN     8'h21
`define DTP_IDX_ICLR    8'h22
`define DTP_IDX_OPTION  8'h81
`define DTP_IDX_PORT_A_DIRECTION   8'h85
`define DTP_IDX_INTERRUPT_CONTROL  8'h8b
// reset values
`define DTP_RST_OPTION  8'hff
`define DTP_RST_PORT_A_DIRECTION   6'h3f
`define DTP_RST_INTERRUPT_CONTROL  8'h00
`define DTP_RST_SECOND_TIMER_CONTROL   8'h00
// timer_option_control fields
`define DTP_OPT_FIRST_TIMER_CLOCK_SELECT    5
`define DTP_OPT_FIRST_TIMER_EDGE_SELECT    4
`define DTP_OPT_PSA     3
// interrupt_control fields
`define DTP_INTERRUPT_CONTROL_FIRST_TIMER_OVERFLOW_ENABLE 5
`define DTP_INTERRUPT_CONTROL_FIRST_TIMER_OVERFLOW_FLAG 2
// second_timer_control fields
`define DTP_T1_ON       0
`define DTP_T1_CS       1
`define DTP_T1_SYNC     2
`define DTP_T1_OSCEN    3
`define DTP_T1_CKPS_LO  4
`define DTP_T1_CKPS_HI  5
// port a pins taken by the crystal
`define DTP_PA_OSC_MASK 6'h30
// interrupt status bit positions
`define DTP_IRQ_T0      0
`define DTP_IRQ_T1      1
// instruction cycle is the master clock divided by four
`define DTP_CYC_DIV     4
`endif

// file: pkg/dtp_pkg.sv
// types shared by the dual timer block
package dtp_pkg;
  // counting source of the second timer
  typedef enum logic [1:0] {
    DTP_T1_INTERNAL = 2'b00,
    DTP_T1_PIN      = 2'b01,
    DTP_T1_CRYSTAL  = 2'b10
  } dtp_t1_src_t;
endpackage : dtp_pkg

// file: hw/dtp_prescale.sv
// power-of-two prescaler: passes one input tick out of every 2**shift for shift up to W, every 2**W above that
`timescale 1ns/10ps
module dtp_prescale #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,   // system clock
  input  wire logic         i_rstn,   // async reset, active low
  input  wire logic         i_tick,   // input event pulse
  input  wire logic [3:0]   i_shift,  // log2 of the ratio
  input  wire logic         i_clr,    // clear the count
  output logic              o_tick,   // divided event pulse
  output logic [W-1:0]      o_count   // current count
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] mask;

  // low bits that must all be one before an event passes
  function automatic logic [W-1:0] low_mask(input logic [3:0] s);
    logic [W:0] one;
    one = {{W{1'b0}}, 1'b1} << s;
    return W'(one - {{W{1'b0}}, 1'b1});
  endfunction : low_mask

  // a clear wins over a tick so a write restarts the ratio cleanly
  assign mask    = low_mask(i_shift);
  assign o_tick  = i_tick & ~i_clr & ((cnt_q & mask) == mask);
  assign cnt_d   = i_clr ? '0 : (i_tick ? cnt_q + 1'b1 : cnt_q);
  assign o_count = cnt_q;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) cnt_q <= '0;
    else         cnt_q <= cnt_d;
  end
endmodule : dtp_prescale

// file: hw/dtp_top.sv
// dual timer clock selection and prescaling with an apb register slave
`timescale 1ns/10ps
`include "dtp_params.svh"
module dtp_top (
  input  wire logic        i_mclk,                        // system clock, 100 MHz
  input  wire logic        i_rstn,                        // async reset, active low
  input  wire logic        i_psel,                        // apb select
  input  wire logic        i_penable,                     // apb enable
  input  wire logic        i_pwrite,                      // apb direction
  input  wire logic [11:0] i_paddr,                       // apb byte address
  input  wire logic [31:0] i_pwdata,                      // apb write data
  output logic      [31:0] o_prdata,                      // apb read data
  output logic             o_pready,                      // apb ready
  output logic             o_pslverr,                     // apb error
  input  wire logic        i_first_timer_count_pin,       // first timer count pin
  input  wire logic        i_second_timer_clock_pin,      // second timer clock pin
  input  wire logic        i_oscillator_input_pin,        // crystal input
  output logic             o_oscillator_amplifier_pin,    // crystal amplifier out
  output logic             o_oscillator_amplifier_pin_oe, // amplifier drive enable
  input  wire logic [5:0]  i_port_a,                      // port a pin levels
  output logic      [5:0]  o_port_a_direction,            // port a direction bits
  input  wire logic        i_sleep,                       // core sleeping
  input  wire logic        i_watchdog_base_tick,          // watchdog base pulse
  output logic             o_watchdog_tick,               // watchdog count pulse
  output logic             o_irq                          // level interrupt
);
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [8:0] meta_q;
  logic [8:0] sync_q;
  logic [8:0] prev_q;
  logic [5:0] port_a_s;
  logic       t0_pin_s;
  logic       t0_pin_p;
  logic       t1_pin_s;
  logic       t1_pin_p;
  logic       osc_s;
  logic       osc_p;

  // only sync_q and prev_q are read by logic
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= 9'h000;
      sync_q <= 9'h000;
      prev_q <= 9'h000;
    end else begin
      meta_q <= {i_oscillator_input_pin, i_second_timer_clock_pin, i_first_timer_count_pin, i_port_a};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign port_a_s = sync_q[5:0];
  assign t0_pin_s = sync_q[6];
  assign t0_pin_p = prev_q[6];
  assign t1_pin_s = sync_q[7];
  assign t1_pin_p = prev_q[7];
  assign osc_s    = sync_q[8];
  assign osc_p    = prev_q[8];

  //////////////////////////////////////////////////////////////////////////////
  // instruction cycle tick, stopped while the core sleeps
  logic [1:0] cyc_q;
  logic       cyc_tick;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) cyc_q <= 2'h0;
    else         cyc_q <= cyc_q + 2'h1;
  end

  assign cyc_tick = (cyc_q == 2'(`DTP_CYC_DIV - 1)) & ~i_sleep;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state so read data comes from a flop
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        acc;
  logic        done;
  logic        wr;
  logic        mapped;
  logic [7:0]  rd_mux;
  logic [7:0]  wd;

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction : hit

  logic h_first_timer_count, h_porta, h_t1l, h_t1h, h_second_timer_control, h_istat, h_ien, h_iclr, h_opt, h_port_a_direction, h_interrupt_control;

  // address decode
  assign h_first_timer_count   = hit(i_paddr, `DTP_IDX_FIRST_TIMER_COUNT);
  assign h_porta  = hit(i_paddr, `DTP_IDX_PORTA);
  assign h_t1l    = hit(i_paddr, `DTP_IDX_T1L);
  assign h_t1h    = hit(i_paddr, `DTP_IDX_T1H);
  assign h_second_timer_control  = hit(i_paddr, `DTP_IDX_SECOND_TIMER_CONTROL);
  assign h_istat  = hit(i_paddr, `DTP_IDX_ISTAT);
  assign h_ien    = hit(i_paddr, `DTP_IDX_IEN);
  assign h_iclr   = hit(i_paddr, `DTP_IDX_ICLR);
  assign h_opt    = hit(i_paddr, `DTP_IDX_OPTION);
  assign h_port_a_direction  = hit(i_paddr, `DTP_IDX_PORT_A_DIRECTION);
  assign h_interrupt_control = hit(i_paddr, `DTP_IDX_INTERRUPT_CONTROL);
  assign mapped   = h_first_timer_count | h_porta | h_t1l | h_t1h | h_second_timer_control | h_istat | h_ien | h_iclr
                  | h_opt | h_port_a_direction | h_interrupt_control;

  // a write lands only at the edge where ready is sampled high
  assign acc  = i_psel & i_penable;
  assign done = acc & pready_q;
  assign wr   = done & i_pwrite & mapped;
  assign wd   = i_pwdata[7:0];

  logic wr_first_timer_count, wr_t1l, wr_t1h, wr_second_timer_control, wr_ien, wr_iclr, wr_opt, wr_port_a_direction, wr_interrupt_control, wr_t1;
  assign wr_first_timer_count   = wr & h_first_timer_count;
  assign wr_t1l    = wr & h_t1l;
  assign wr_t1h    = wr & h_t1h;
  assign wr_t1     = wr_t1l | wr_t1h;
  assign wr_second_timer_control  = wr & h_second_timer_control;
  assign wr_ien    = wr & h_ien;
  assign wr_iclr   = wr & h_iclr;
  assign wr_opt    = wr & h_opt;
  assign wr_port_a_direction  = wr & h_port_a_direction;
  assign wr_interrupt_control = wr & h_interrupt_control;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc & ~pready_q;
      prdata_q  <= (acc & ~pready_q) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      pslverr_q <= acc & ~pready_q & ~mapped;
    end
  end

  assign o_pready  = pready_q;
  assign o_prdata  = prdata_q;
  assign o_pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [7:0]  opt_q, interrupt_control_q, interrupt_control_d, second_timer_control_q, t0_cnt_q, t0_cnt_d;
  logic [5:0]  port_a_direction_q, port_a_direction_d, osc_pins;
  logic [15:0] t1_cnt_q, t1_cnt_d;
  logic [1:0]  istat_q, istat_d, ien_q;
  logic        osc_en;

  assign osc_en   = second_timer_control_q[`DTP_T1_OSCEN];
  assign osc_pins = osc_en ? `DTP_PA_OSC_MASK : 6'h00;

  // read mux; port pins used by the crystal read as zero
  assign rd_mux = h_first_timer_count   ? t0_cnt_q :
                  h_porta  ? {2'b00, port_a_s & ~osc_pins} :
                  h_t1l    ? t1_cnt_q[7:0] :
                  h_t1h    ? t1_cnt_q[15:8] :
                  h_second_timer_control  ? second_timer_control_q :
                  h_istat  ? {6'h00, istat_q} :
                  h_ien    ? {6'h00, ien_q} :
                  h_opt    ? opt_q :
                  h_port_a_direction  ? {2'b00, port_a_direction_q} :
                  h_interrupt_control ? interrupt_control_q : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // first timer and the shared prescaler
  logic       t0_edge, t0_src, prescaler_assign, pre0_in, pre0_tick, t0_inc, t0_ovf, wdt_pulse;
  logic [3:0] pre0_shift;
  logic [2:0] rate;
  logic [7:0] pre0_count;

  assign prescaler_assign  = opt_q[`DTP_OPT_PSA];
  assign rate = opt_q[2:0];
  // edge of the count pin, halted with the core clock in sleep
  assign t0_edge    = (opt_q[`DTP_OPT_FIRST_TIMER_EDGE_SELECT] ? (t0_pin_p & ~t0_pin_s) : (~t0_pin_p & t0_pin_s)) & ~i_sleep;
  assign t0_src     = opt_q[`DTP_OPT_FIRST_TIMER_CLOCK_SELECT] ? t0_edge : cyc_tick;
  assign pre0_in    = prescaler_assign ? i_watchdog_base_tick : t0_src;
  // the first timer ratio is one step above the watchdog ratio
  assign pre0_shift = prescaler_assign ? {1'b0, rate} : {1'b0, rate} + 4'h1;
  assign t0_inc     = prescaler_assign ? t0_src : pre0_tick;
  assign wdt_pulse  = prescaler_assign ? pre0_tick : i_watchdog_base_tick;
  assign t0_ovf     = t0_inc & (t0_cnt_q == 8'hff) & ~wr_first_timer_count;
  assign t0_cnt_d   = wr_first_timer_count ? wd : (t0_inc ? t0_cnt_q + 8'h01 : t0_cnt_q);

  dtp_prescale #(.W(8)) u_pre0 (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_tick  (pre0_in),
    .i_shift (pre0_shift),
    .i_clr   (wr_first_timer_count & ~prescaler_assign),
    .o_tick  (pre0_tick),
    .o_count (pre0_count)
  );

  // overflow flag: a hardware set beats a software clear
  assign interrupt_control_d = (wr_interrupt_control ? wd : interrupt_control_q) | (t0_ovf ? (8'h01 << `DTP_INTERRUPT_CONTROL_FIRST_TIMER_OVERFLOW_FLAG) : 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  // second timer
  dtp_pkg::dtp_t1_src_t t1_sel;
  logic       t1_on, t1_byp, ext_cur, ext_prev, ext_rise, ext_fall, ext_evt, t1_src;
  logic       pre1_tick, t1_ovf, armed_q, armed_d, lvl_dis_q, on_next, reen_low;
  logic [7:0] pre1_count;

  assign t1_on  = second_timer_control_q[`DTP_T1_ON];
  assign t1_byp = second_timer_control_q[`DTP_T1_SYNC];
  assign t1_sel = !second_timer_control_q[`DTP_T1_CS] ? dtp_pkg::DTP_T1_INTERNAL :
                  osc_en ? dtp_pkg::DTP_T1_CRYSTAL : dtp_pkg::DTP_T1_PIN;
  // crystal replaces the clock pin when running
  assign ext_cur  = (t1_sel == dtp_pkg::DTP_T1_CRYSTAL) ? osc_s : t1_pin_s;
  assign ext_prev = (t1_sel == dtp_pkg::DTP_T1_CRYSTAL) ? osc_p : t1_pin_p;
  assign ext_rise = ~ext_prev & ext_cur;
  assign ext_fall = ext_prev & ~ext_cur;
  // synchronised counting stops with the core clock; bypass keeps going
  assign ext_evt  = ext_rise & armed_q & (t1_byp | ~i_sleep);
  assign t1_src   = (t1_sel == dtp_pkg::DTP_T1_INTERNAL) ? cyc_tick : ext_evt;

  dtp_prescale #(.W(8)) u_pre1 (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_tick  (t1_src & t1_on),
    .i_shift ({2'b00, second_timer_control_q[`DTP_T1_CKPS_HI:`DTP_T1_CKPS_LO]}),
    .i_clr   (wr_t1),
    .o_tick  (pre1_tick),
    .o_count (pre1_count)
  );

  assign t1_ovf   = pre1_tick & (t1_cnt_q == 16'hffff);
  assign t1_cnt_d = wr_t1l ? {t1_cnt_q[15:8], wd} :
                    wr_t1h ? {wd, t1_cnt_q[7:0]} :
                    pre1_tick ? t1_cnt_q + 16'h0001 : t1_cnt_q;

  // arming: reset, a count write or a low re-enable after a high disable disarm
  assign on_next  = wr_second_timer_control ? wd[`DTP_T1_ON] : t1_on;
  assign reen_low = on_next & ~t1_on & lvl_dis_q & ~ext_cur;
  assign armed_d  = (wr_t1 | reen_low) ? 1'b0 : (ext_fall ? 1'b1 : armed_q);

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and write-one clear; set beats clear
  assign istat_d = (istat_q & ~(wr_iclr ? i_pwdata[1:0] : 2'b00))
                 | (2'(t0_ovf) << `DTP_IRQ_T0) | (2'(t1_ovf) << `DTP_IRQ_T1);
  // crystal forces its two direction bits to one
  assign port_a_direction_d = (wr_port_a_direction ? wd[5:0] : port_a_direction_q) | osc_pins;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      opt_q     <= `DTP_RST_OPTION;
      interrupt_control_q  <= `DTP_RST_INTERRUPT_CONTROL;
      second_timer_control_q   <= `DTP_RST_SECOND_TIMER_CONTROL;
      port_a_direction_q   <= `DTP_RST_PORT_A_DIRECTION;
      t0_cnt_q  <= 8'h00;
      t1_cnt_q  <= 16'h0000;
      istat_q   <= 2'h0;
      ien_q     <= 2'h0;
      armed_q   <= 1'b0;
      lvl_dis_q <= 1'b0;
    end else begin
      opt_q     <= wr_opt ? wd : opt_q;
      interrupt_control_q  <= interrupt_control_d;
      second_timer_control_q   <= wr_second_timer_control ? wd : second_timer_control_q;
      port_a_direction_q   <= port_a_direction_d;
      t0_cnt_q  <= t0_cnt_d;
      t1_cnt_q  <= t1_cnt_d;
      istat_q   <= istat_d;
      ien_q     <= wr_ien ? i_pwdata[1:0] : ien_q;
      armed_q   <= armed_d;
      lvl_dis_q <= (t1_on & ~on_next) ? ext_cur : lvl_dis_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops; the crystal amplifier ignores sleep
  logic irq_q, wdt_q, amp_q, amp_oe_q;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_q    <= 1'b0;
      wdt_q    <= 1'b0;
      amp_q    <= 1'b0;
      amp_oe_q <= 1'b0;
    end else begin
      irq_q    <= |(istat_q & ien_q);
      wdt_q    <= wdt_pulse;
      amp_q    <= osc_en & ~osc_s;
      amp_oe_q <= osc_en;
    end
  end

  assign o_irq                         = irq_q;
  assign o_watchdog_tick               = wdt_q;
  assign o_oscillator_amplifier_pin    = amp_q;
  assign o_oscillator_amplifier_pin_oe = amp_oe_q;
  assign o_port_a_direction            = port_a_direction_q;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence s_count_write;
    wr_t1l || wr_t1h;
  endsequence
  sequence s_disarmed_then_fall;
    !armed_q ##0 ext_fall && !wr_t1;
  endsequence

  t0_wrap_flag_a: assert property (t0_ovf |=> t0_cnt_q == 8'h00 && interrupt_control_q[`DTP_INTERRUPT_CONTROL_FIRST_TIMER_OVERFLOW_FLAG])
    else $error("first timer wrap did not clear count and set flag");
  t0_cycle_src_a: assert property (prescaler_assign && !opt_q[`DTP_OPT_FIRST_TIMER_CLOCK_SELECT] && cyc_tick && !wr_first_timer_count
    |=> t0_cnt_q == $past(t0_cnt_q) + 8'h01)
    else $error("first timer missed an instruction cycle");
  t0_pin_edge_a: assert property (prescaler_assign && opt_q[`DTP_OPT_FIRST_TIMER_CLOCK_SELECT] && opt_q[`DTP_OPT_FIRST_TIMER_EDGE_SELECT] && !i_sleep
    && t0_pin_p && !t0_pin_s && !wr_first_timer_count |=> t0_cnt_q == $past(t0_cnt_q) + 8'h01)
    else $error("first timer missed a falling pin edge");
  wdt_direct_a: assert property (!prescaler_assign && i_watchdog_base_tick |=> o_watchdog_tick)
    else $error("watchdog pulse lost without prescaler");
  wdt_rate_one_a: assert property (prescaler_assign && rate == 3'h0 && i_watchdog_base_tick |=> o_watchdog_tick)
    else $error("watchdog ratio not one to one at rate zero");
  t0_half_rate_a: assert property (!prescaler_assign && rate == 3'h0 && pre0_in && !pre0_count[0] && !wr_first_timer_count
    |=> t0_cnt_q == $past(t0_cnt_q))
    else $error("first timer counted on the first of two ticks");
  t1_internal_a: assert property (t1_on && t1_sel == dtp_pkg::DTP_T1_INTERNAL
    && second_timer_control_q[`DTP_T1_CKPS_HI:`DTP_T1_CKPS_LO] == 2'h0 && cyc_tick && !wr_t1
    |=> t1_cnt_q == $past(t1_cnt_q) + 16'h0001)
    else $error("second timer missed an instruction cycle");
  t1_div8_a: assert property (pre1_tick && second_timer_control_q[`DTP_T1_CKPS_HI:`DTP_T1_CKPS_LO] == 2'h3
    |-> pre1_count[2:0] == 3'h7)
    else $error("second timer prescale by eight off");
  t1_clear_a: assert property (s_count_write |=> pre1_count == 8'h00 && !armed_q)
    else $error("count write did not clear prescaler and arming");
  t1_arm_a: assert property (s_disarmed_then_fall |=> armed_q)
    else $error("falling edge did not arm the second timer");
  t1_sync_sleep_a: assert property (i_sleep && !t1_byp && !wr_t1 |=> t1_cnt_q == $past(t1_cnt_q))
    else $error("synchronised second timer counted in sleep");
  t1_async_sleep_a: assert property (t1_on && t1_sel != dtp_pkg::DTP_T1_INTERNAL && t1_byp
    && i_sleep && ext_rise && armed_q && second_timer_control_q[5:4] == 2'h0 && !wr_t1
    |=> t1_cnt_q == $past(t1_cnt_q) + 16'h0001)
    else $error("asynchronous second timer stopped in sleep");
  t1_wrap_a: assert property (t1_ovf && !wr_t1 |=> t1_cnt_q == 16'h0000 && istat_q[`DTP_IRQ_T1])
    else $error("second timer wrap lost");
  osc_dir_a: assert property (osc_en |=> o_port_a_direction[5:4] == 2'b11)
    else $error("crystal pins not forced to input");
  osc_run_a: assert property (osc_en |=> o_oscillator_amplifier_pin_oe)
    else $error("crystal amplifier not driven");
endmodule : dtp_top

// file: verif/dtp_pin_model.sv
// far-side model: pulse source on the external count pins
`timescale 1ns/10ps
module dtp_pin_model (
  input  wire logic i_mclk, // system clock
  output logic      o_pin   // count pin level, idles low
);
  initial o_pin = 1'b0;
  // set a steady level, used to step single edges
  task automatic level(input logic v);
    @(posedge i_mclk);
    o_pin <= v;
  endtask : level
  // whole pulses starting low, so the first rise after a count write is not counted
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge i_mclk);
      o_pin <= 1'b1;
      repeat (8) @(posedge i_mclk);
      o_pin <= 1'b0;
    end
  endtask : pulses
endmodule : dtp_pin_model

// file: verif/dtp_top_tb.sv
// self-checking bench for the dual timer block
`timescale 1ns/10ps
`include "dtp_params.svh"
module dtp_top_tb;
  logic        i_mclk, i_rstn, psel, penable, pwrite, pready, pslverr, sleep, wdb, wdt, irq, amp, amp_oe, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  port_a, dir;
  logic [7:0]  last_rd;
  logic        last_err;
  int          failures, comparisons, wd_cnt;
  dtp_top dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_first_timer_count_pin(pin), .i_second_timer_clock_pin(pin), .i_oscillator_input_pin(pin),
    .o_oscillator_amplifier_pin(amp), .o_oscillator_amplifier_pin_oe(amp_oe), .i_port_a(port_a),
    .o_port_a_direction(dir), .i_sleep(sleep), .i_watchdog_base_tick(wdb), .o_watchdog_tick(wdt), .o_irq(irq));
  dtp_pin_model model (.i_mclk(i_mclk), .o_pin(pin));
  ////////////////////////////////////////////////////////////////
  // clock, and a counter of watchdog pulses sampled at each rising edge
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) if (wdt === 1'b1) wd_cnt++;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer; values read at the edge are the pre-edge registered outputs
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge i_mclk);
    penable <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    last_rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_mclk);
  endtask : apb
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(0, `DTP_IDX_OPTION, 0);
    chk("option", 8'hff, last_rd);
    apb(0, `DTP_IDX_PORT_A_DIRECTION, 0);
    chk("direction", 8'h3f, last_rd);
    apb(0, `DTP_IDX_INTERRUPT_CONTROL, 0);
    chk("interrupt_control", 8'h00, last_rd);
    apb(0, 8'h40, 0);
    chk("unmapped err", 1'b1, last_err);
  endtask : t_reset
  // first timer from instruction cycles, wrap sets flag and raises irq
  task automatic t_first;
    apb(1, `DTP_IDX_OPTION, 8'h08);
    apb(1, `DTP_IDX_FIRST_TIMER_COUNT, 8'hf0);
    repeat (100) @(posedge i_mclk);
    apb(0, `DTP_IDX_INTERRUPT_CONTROL, 0);
    chk("wrap flag", 1'b1, last_rd[2]);
    apb(1, `DTP_IDX_IEN, 8'h01);
    repeat (2) @(posedge i_mclk);
    chk("irq on", 1'b1, irq);
    apb(1, `DTP_IDX_ICLR, 8'h01);
    repeat (2) @(posedge i_mclk);
    chk("irq off", 1'b0, irq);
    // pin source, falling edges only
    apb(1, `DTP_IDX_OPTION, 8'h38);
    apb(1, `DTP_IDX_FIRST_TIMER_COUNT, 8'h00);
    model.level(1'b1);
    repeat (8) @(posedge i_mclk);
    apb(0, `DTP_IDX_FIRST_TIMER_COUNT, 0);
    chk("rise ignored", 8'h00, last_rd);
    model.level(1'b0);
    repeat (8) @(posedge i_mclk);
    apb(0, `DTP_IDX_FIRST_TIMER_COUNT, 0);
    chk("fall counted", 8'h01, last_rd);
  endtask : t_first
  // watchdog output over 256 base pulses for one option value
  task automatic wd_run(input logic [7:0] opt, input int exp);
    apb(1, `DTP_IDX_OPTION, opt);
    wd_cnt = 0;
    repeat (256) begin
      wdb <= 1'b1;
      @(posedge i_mclk);
      wdb <= 1'b0;
      @(posedge i_mclk);
    end
    repeat (4) @(posedge i_mclk);
    chk("watchdog ticks", exp, wd_cnt);
  endtask : wd_run
  task automatic t_watchdog;
    wd_run(8'h07, 256);
    for (int r = 0; r < 8; r++) wd_run(8'h08 | r[7:0], 256 >> r);
  endtask : t_watchdog
  // second timer on the pin, every prescale code, async for the odd codes and asleep for the last
  task automatic t_second;
    for (int k = 0; k < 4; k++) begin
      sleep <= (k == 3);
      apb(1, `DTP_IDX_SECOND_TIMER_CONTROL, {2'b00, k[1:0], 1'b0, k[0], 2'b11});
      apb(1, `DTP_IDX_T1L, 8'h00);
      apb(1, `DTP_IDX_T1H, 8'h00);
      model.pulses(9);
      repeat (8) @(posedge i_mclk);
      apb(0, `DTP_IDX_T1L, 0);
      chk("second count", 8 >> k, last_rd);
    end
    sleep <= 1'b0;
    apb(1, `DTP_IDX_SECOND_TIMER_CONTROL, 8'h01);
    apb(1, `DTP_IDX_T1L, 8'h00);
    repeat (400) @(posedge i_mclk);
    apb(0, `DTP_IDX_T1L, 0);
    chk("internal rate", 1'b1, last_rd >= 8'd98 && last_rd <= 8'd103);
  endtask : t_second
  // crystal enable takes pins 5 and 4
  task automatic t_crystal;
    port_a <= 6'h3f;
    apb(1, `DTP_IDX_PORT_A_DIRECTION, 8'h00);
    // main clock is the internal one here, so the shared crystal may be enabled
    apb(1, `DTP_IDX_SECOND_TIMER_CONTROL, 8'h08);
    // outputs launched at the edge the task returns on; let two more edges pass, and the
    // timer stays off through the crystal start-up wait
    repeat (2) @(posedge i_mclk);
    chk("amp enable", 1'b1, amp_oe);
    chk("amp level", 1'b1, amp);
    chk("direction pins", 6'h30, dir);
    apb(0, `DTP_IDX_PORT_A_DIRECTION, 0);
    chk("direction read", 8'h30, last_rd);
    apb(0, `DTP_IDX_PORTA, 0);
    chk("port read", 8'h0f, last_rd);
  endtask : t_crystal
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (40000) @(posedge i_mclk);
    failures++;
    print_verdict();
  end
  initial begin
    {i_rstn, psel, penable, pwrite, sleep, wdb} = '0;
    {paddr, pwdata, port_a} = '0;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_mclk);
    t_reset();
    t_first();
    t_watchdog();
    t_second();
    t_crystal();
    print_verdict();
  end
endmodule : dtp_top_tb
